// *** rtl/stw_pkg.sv ***
package stw_pkg;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned REG_NUM = 2 ** ADDR_W;
    localparam int unsigned FRAME_BITS = 16;
    // Direction flag values carried in bit 7 of the address byte
    localparam logic DIR_WRITE = 1'h1;
    localparam logic DIR_READ = 1'h0;
    // Pin synchroniser reset levels: power-down, clock, data idle high
    localparam logic [2:0] PIN_RST = 3'h7;
    localparam logic SDIO_IDLE = 1'h1;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    // Times in their own units, cycle counts derived from the clock
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned PD_LEAD_NS = 1000;
    localparam int unsigned PD_PULSE_US = 700;
    localparam int unsigned WDOG_US = 1700;
    localparam int unsigned SCLK_HALF_NS = 80;
    localparam logic [CNT_W-1:0] PD_LEAD_CYC = CNT_W'(
        (PD_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] PD_PULSE_CYC = CNT_W'(
        (PD_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WDOG_CYC = CNT_W'(
        (WDOG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SCLK_HALF_CYC = CNT_W'(
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Host waits a little past the device timeout to cover sync latency
    localparam logic [CNT_W-1:0] WDOG_MARGIN_CYC = 20'h00010;

    typedef enum logic [1:0] {
        STW_DEV_ADDR  = 2'h0,
        STW_DEV_WDATA = 2'h1,
        STW_DEV_RDATA = 2'h2
    } stw_dev_state_t;

    typedef enum logic [2:0] {
        STW_HST_IDLE    = 3'h0,
        STW_HST_LOW     = 3'h1,
        STW_HST_HIGH    = 3'h2,
        STW_HST_PD_LEAD = 3'h3,
        STW_HST_PD_LOW  = 3'h4,
        STW_HST_PD_HOLD = 3'h5,
        STW_HST_WD_LOW  = 3'h6,
        STW_HST_WD_WAIT = 3'h7
    } stw_hst_state_t;
endpackage

// *** rtl/stw_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface stw_link_if;
    logic sclk;
    logic power_down_pin;
    logic host_sdio_out;
    logic host_sdio_oe;
    logic dev_sdio_out;
    logic dev_sdio_oe;
    logic sdio;

    // Shared data wire with a pull-up when nobody drives
    assign sdio = host_sdio_oe ? host_sdio_out
                : dev_sdio_oe  ? dev_sdio_out
                : stw_pkg::SDIO_IDLE;

    modport dev (
        input  sclk,
        input  power_down_pin,
        input  sdio,
        output dev_sdio_out,
        output dev_sdio_oe
    );

    modport host (
        output sclk,
        output power_down_pin,
        output host_sdio_out,
        output host_sdio_oe,
        input  sdio
    );
endinterface
`default_nettype wire

// *** rtl/stw_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module stw_pin_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // First stage feeds only the second
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            prev_q <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sync_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;
endmodule
`default_nettype wire

// *** rtl/stw_device.sv ***
`timescale 1ns/100ps
`default_nettype none
module stw_device #(
    parameter logic [stw_pkg::CNT_W-1:0] WDOG_CYC = stw_pkg::WDOG_CYC
) (
    input  wire logic                        clock_i,
    input  wire logic                        reset_i,
    stw_link_if.dev                          link,
    output logic                             wr_valid_o,
    output logic [stw_pkg::ADDR_W-1:0]       wr_addr_o,
    output logic [stw_pkg::DATA_W-1:0]       wr_data_o,
    output logic                             rd_done_o,
    output logic                             shutdown_o
);
    localparam int unsigned AW = stw_pkg::ADDR_W;
    localparam int unsigned DW = stw_pkg::DATA_W;
    localparam int unsigned CW = stw_pkg::CNT_W;

    logic [2:0] pin_s;
    logic [2:0] pin_r;
    logic [2:0] pin_f;
    logic       pd_s;
    logic       sclk_r;
    logic       sclk_f;
    logic       sdio_s;

    stw_pkg::stw_dev_state_t st_q;
    stw_pkg::stw_dev_state_t st_d;
    logic [2:0]    cnt_q;
    logic [2:0]    cnt_d;
    logic [DW-1:0] sh_q;
    logic [DW-1:0] sh_d;
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_d;
    logic          oe_q;
    logic          oe_d;
    logic          out_q;
    logic          out_d;
    logic [CW-1:0] wd_q;
    logic [CW-1:0] wd_d;
    logic [DW-1:0] regs_q [stw_pkg::REG_NUM];
    logic [DW-1:0] regs_d [stw_pkg::REG_NUM];
    logic          wr_valid_q;
    logic          wr_valid_d;
    logic [AW-1:0] wr_addr_q;
    logic [AW-1:0] wr_addr_d;
    logic [DW-1:0] wr_data_q;
    logic [DW-1:0] wr_data_d;
    logic          rd_done_q;
    logic          rd_done_d;
    logic          shut_q;
    logic          port_busy;
    logic [DW-1:0] byte_in;

    // Clock, data and power-down all come from the far side
    stw_pin_sync #(
        .W       (3),
        .RST_VAL (stw_pkg::PIN_RST)
    ) u_pin_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i ({link.power_down_pin, link.sclk, link.sdio}),
        .sync_o  (pin_s),
        .rise_o  (pin_r),
        .fall_o  (pin_f)
    );

    assign pd_s   = pin_s[2];
    assign sclk_r = pin_r[1];
    assign sclk_f = pin_f[1];
    assign sdio_s = pin_s[0];

    // Byte as completed by the current rising edge, first bit on top
    assign byte_in   = {sh_q[DW-2:0], sdio_s};
    assign port_busy = (st_q != stw_pkg::STW_DEV_ADDR) || (cnt_q != 3'h0);

    always_comb begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        sh_d       = sh_q;
        addr_d     = addr_q;
        oe_d       = oe_q;
        out_d      = out_q;
        wd_d       = wd_q;
        regs_d     = regs_q;
        wr_valid_d = 1'h0;
        wr_addr_d  = wr_addr_q;
        wr_data_d  = wr_data_q;
        rd_done_d  = 1'h0;
        if (pd_s) begin
            // Abort or resync: port logic only, registers untouched
            st_d  = stw_pkg::STW_DEV_ADDR;
            cnt_d = 3'h0;
            oe_d  = 1'h0;
            wd_d  = '0;
        end else if (wd_q >= WDOG_CYC) begin
            // Stalled mid-frame for the timeout: restart the port
            st_d  = stw_pkg::STW_DEV_ADDR;
            cnt_d = 3'h0;
            oe_d  = 1'h0;
            wd_d  = '0;
        end else begin
            if (sclk_r || sclk_f || !port_busy) begin
                wd_d = '0;
            end else begin
                wd_d = wd_q + 1'h1;
            end
            // Every action except the default recovery waits for a host clock edge
            unique case (st_q)
                stw_pkg::STW_DEV_ADDR: begin
                    if (sclk_r) begin
                        sh_d  = byte_in;
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            addr_d = byte_in[AW-1:0];
                            cnt_d  = 3'h0;
                            if (byte_in[DW-1] == stw_pkg::DIR_WRITE) begin
                                st_d = stw_pkg::STW_DEV_WDATA;
                            end else begin
                                st_d = stw_pkg::STW_DEV_RDATA;
                                sh_d = regs_q[byte_in[AW-1:0]];
                            end
                        end
                    end
                end
                stw_pkg::STW_DEV_WDATA: begin
                    if (sclk_r) begin
                        // Data sampled on the rising edge
                        sh_d  = byte_in;
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            regs_d[addr_q] = byte_in;
                            wr_valid_d     = 1'h1;
                            wr_addr_d      = addr_q;
                            wr_data_d      = byte_in;
                            cnt_d          = 3'h0;
                            st_d           = stw_pkg::STW_DEV_ADDR;
                        end
                    end
                end
                stw_pkg::STW_DEV_RDATA: begin
                    if (sclk_f) begin
                        // Drive begins only on the falling edge after
                        // the last address bit, and moves only there
                        oe_d  = 1'h1;
                        out_d = sh_q[DW-1];
                        sh_d  = {sh_q[DW-2:0], 1'h0};
                    end else if (sclk_r && oe_q) begin
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            // last_data_bit held up to this rising edge
                            oe_d      = 1'h0;
                            cnt_d     = 3'h0;
                            rd_done_d = 1'h1;
                            st_d      = stw_pkg::STW_DEV_ADDR;
                        end
                    end
                end
                default: begin
                    st_d  = stw_pkg::STW_DEV_ADDR;
                    cnt_d = 3'h0;
                    oe_d  = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            st_q       <= stw_pkg::STW_DEV_ADDR;
            cnt_q      <= 3'h0;
            sh_q       <= '0;
            addr_q     <= '0;
            oe_q       <= 1'h0;
            out_q      <= stw_pkg::SDIO_IDLE;
            wd_q       <= '0;
            wr_valid_q <= 1'h0;
            wr_addr_q  <= '0;
            wr_data_q  <= '0;
            rd_done_q  <= 1'h0;
            shut_q     <= 1'h1;
            for (int i = 0; i < stw_pkg::REG_NUM; i++) begin
                regs_q[i] <= stw_pkg::REG_RST;
            end
        end else begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            sh_q       <= sh_d;
            addr_q     <= addr_d;
            oe_q       <= oe_d;
            out_q      <= out_d;
            wd_q       <= wd_d;
            wr_valid_q <= wr_valid_d;
            wr_addr_q  <= wr_addr_d;
            wr_data_q  <= wr_data_d;
            rd_done_q  <= rd_done_d;
            shut_q     <= pd_s;
            regs_q     <= regs_d;
        end
    end

    assign link.dev_sdio_out = out_q;
    assign link.dev_sdio_oe  = oe_q;
    assign wr_valid_o        = wr_valid_q;
    assign wr_addr_o         = wr_addr_q;
    assign wr_data_o         = wr_data_q;
    assign rd_done_o         = rd_done_q;
    assign shutdown_o        = shut_q;
endmodule
`default_nettype wire

// *** rtl/stw_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module stw_host #(
    parameter logic [stw_pkg::CNT_W-1:0] HALF_CYC  = stw_pkg::SCLK_HALF_CYC,
    parameter logic [stw_pkg::CNT_W-1:0] PD_CYC    = stw_pkg::PD_PULSE_CYC,
    parameter logic [stw_pkg::CNT_W-1:0] WDOG_WAIT =
        stw_pkg::WDOG_CYC + stw_pkg::WDOG_MARGIN_CYC
) (
    input  wire logic                        clock_i,
    input  wire logic                        reset_i,
    stw_link_if.host                         link,
    input  wire logic                        cmd_valid_i,
    input  wire logic                        cmd_write_i,
    input  wire logic [stw_pkg::ADDR_W-1:0]  cmd_addr_i,
    input  wire logic [stw_pkg::DATA_W-1:0]  cmd_data_i,
    input  wire logic                        resync_pd_i,
    input  wire logic                        resync_wdog_i,
    output logic                             cmd_ready_o,
    output logic                             rsp_valid_o,
    output logic [stw_pkg::DATA_W-1:0]       rsp_data_o
);
    localparam int unsigned DW = stw_pkg::DATA_W;
    localparam int unsigned FB = stw_pkg::FRAME_BITS;

    logic sdio_s;
    stw_pkg::stw_hst_state_t st_q;
    stw_pkg::stw_hst_state_t st_d;
    logic [stw_pkg::CNT_W-1:0] tim_q;
    logic [stw_pkg::CNT_W-1:0] tim_d;
    logic [4:0]    bit_q;
    logic [4:0]    bit_d;
    logic [FB-1:0] sh_q;
    logic [FB-1:0] sh_d;
    logic [DW-1:0] rx_q;
    logic [DW-1:0] rx_d;
    logic          wr_q;
    logic          wr_d;
    logic          sclk_q;
    logic          sclk_d;
    logic          pd_q;
    logic          pd_d;
    logic          sdo_q;
    logic          sdo_d;
    logic          oe_q;
    logic          oe_d;
    logic          rdy_q;
    logic          rdy_d;
    logic          rsp_q;
    logic          rsp_d;
    logic          tim_end;

    stw_pin_sync #(
        .W       (1),
        .RST_VAL (stw_pkg::SDIO_IDLE)
    ) u_sdio_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i (link.sdio),
        .sync_o  (sdio_s),
        .rise_o  (),
        .fall_o  ()
    );

    assign tim_end = (tim_q == HALF_CYC - 1'h1);

    always_comb begin
        st_d   = st_q;
        tim_d  = tim_q + 1'h1;
        bit_d  = bit_q;
        sh_d   = sh_q;
        rx_d   = rx_q;
        wr_d   = wr_q;
        sclk_d = sclk_q;
        pd_d   = pd_q;
        sdo_d  = sdo_q;
        oe_d   = oe_q;
        rdy_d  = 1'h0;
        rsp_d  = 1'h0;
        unique case (st_q)
            stw_pkg::STW_HST_IDLE: begin
                tim_d = '0;
                rdy_d = 1'h1;
                if (resync_pd_i) begin
                    pd_d  = 1'h1;
                    rdy_d = 1'h0;
                    st_d  = stw_pkg::STW_HST_PD_LEAD;
                end else if (resync_wdog_i) begin
                    sclk_d = 1'h0;
                    rdy_d  = 1'h0;
                    st_d   = stw_pkg::STW_HST_WD_LOW;
                end else if (cmd_valid_i && rdy_q) begin
                    wr_d = cmd_write_i;
                    sh_d = {(cmd_write_i ? stw_pkg::DIR_WRITE
                                         : stw_pkg::DIR_READ),
                            cmd_addr_i, cmd_data_i};
                    sclk_d = 1'h0;
                    sdo_d  = cmd_write_i;
                    oe_d   = 1'h1;
                    bit_d  = 5'h00;
                    rdy_d  = 1'h0;
                    st_d   = stw_pkg::STW_HST_LOW;
                end
            end
            stw_pkg::STW_HST_LOW: begin
                if (tim_end) begin
                    sclk_d = 1'h1;
                    tim_d  = '0;
                    rx_d   = {rx_q[DW-2:0], sdio_s};
                    st_d   = stw_pkg::STW_HST_HIGH;
                end
            end
            stw_pkg::STW_HST_HIGH: begin
                if (tim_end) begin
                    tim_d = '0;
                    if (bit_q == 5'(FB - 1)) begin
                        rsp_d = !wr_q;
                        rdy_d = 1'h1;
                        st_d  = stw_pkg::STW_HST_IDLE;
                    end else begin
                        sclk_d = 1'h0;
                        bit_d  = bit_q + 5'h01;
                        sh_d   = {sh_q[FB-2:0], 1'h0};
                        sdo_d  = sh_q[FB-2];
                        if (!wr_q && bit_q >= 5'h07) begin
                            oe_d = 1'h0;
                        end
                        st_d = stw_pkg::STW_HST_LOW;
                    end
                end
            end
            stw_pkg::STW_HST_PD_LEAD: begin
                if (tim_q == stw_pkg::PD_LEAD_CYC - 1'h1) begin
                    sclk_d = 1'h0;
                    tim_d  = '0;
                    st_d   = stw_pkg::STW_HST_PD_LOW;
                end
            end
            stw_pkg::STW_HST_PD_LOW: begin
                if (tim_end) begin
                    // Pulse length counted from the rising clock
                    sclk_d = 1'h1;
                    tim_d  = '0;
                    st_d   = stw_pkg::STW_HST_PD_HOLD;
                end
            end
            stw_pkg::STW_HST_PD_HOLD: begin
                if (tim_q >= PD_CYC) begin
                    pd_d = 1'h0;
                    st_d = stw_pkg::STW_HST_IDLE;
                end
            end
            stw_pkg::STW_HST_WD_LOW: begin
                if (tim_end) begin
                    sclk_d = 1'h1;
                    tim_d  = '0;
                    st_d   = stw_pkg::STW_HST_WD_WAIT;
                end
            end
            stw_pkg::STW_HST_WD_WAIT: begin
                if (tim_q >= WDOG_WAIT) begin
                    st_d = stw_pkg::STW_HST_IDLE;
                end
            end
            default: begin
                st_d = stw_pkg::STW_HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            st_q   <= stw_pkg::STW_HST_IDLE;
            tim_q  <= '0;
            bit_q  <= 5'h00;
            sh_q   <= '0;
            rx_q   <= '0;
            wr_q   <= 1'h0;
            sclk_q <= 1'h1;
            pd_q   <= 1'h0;
            sdo_q  <= stw_pkg::SDIO_IDLE;
            oe_q   <= 1'h0;
            rdy_q  <= 1'h0;
            rsp_q  <= 1'h0;
        end else begin
            st_q   <= st_d;
            tim_q  <= tim_d;
            bit_q  <= bit_d;
            sh_q   <= sh_d;
            rx_q   <= rx_d;
            wr_q   <= wr_d;
            sclk_q <= sclk_d;
            pd_q   <= pd_d;
            sdo_q  <= sdo_d;
            oe_q   <= oe_d;
            rdy_q  <= rdy_d;
            rsp_q  <= rsp_d;
        end
    end

    assign link.sclk           = sclk_q;
    assign link.power_down_pin = pd_q;
    assign link.host_sdio_out  = sdo_q;
    assign link.host_sdio_oe   = oe_q;
    assign cmd_ready_o         = rdy_q;
    assign rsp_valid_o         = rsp_q;
    assign rsp_data_o          = rx_q;
endmodule
`default_nettype wire

// *** sim/stw_link_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module stw_link_props (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic sclk,
    input wire logic power_down_pin,
    input wire logic host_sdio_out,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_out,
    input wire logic dev_sdio_oe
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // Device takes the line only in a low clock phase after the host let go
    sequence s_dev_start;
        $rose(dev_sdio_oe) && !sclk && !host_sdio_oe;
    endsequence
    sequence s_dev_drive;
        (dev_sdio_oe && !host_sdio_oe) [*8];
    endsequence

    AST_DEV_TAKES_LINE: assert property (
        $rose(dev_sdio_oe) |-> s_dev_start ##1 s_dev_drive)
        else $error("device took the data line at the wrong moment");
    AST_NO_CONTENTION: assert property (
        !(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive the data line");
    AST_HOST_SHIFT_FALL: assert property (
        host_sdio_oe && $changed(host_sdio_out) |-> !sclk)
        else $error("host data changed while the clock was high");
    AST_DEV_SHIFT_FALL: assert property (
        dev_sdio_oe && $changed(dev_sdio_out) |-> !sclk)
        else $error("device data changed while the clock was high");
    AST_DEV_RELEASE_RISE: assert property (
        $fell(dev_sdio_oe) |-> sclk)
        else $error("device released the line outside a high clock phase");
    AST_DEV_HOLD_LAST: assert property (
        dev_sdio_oe && $rose(sclk) |->
            (dev_sdio_oe && $stable(dev_sdio_out)) [*3])
        else $error("device bit not held across the rising clock");
    AST_PD_QUIETS_DEV: assert property (
        power_down_pin [*6] |-> !dev_sdio_oe)
        else $error("device drives the line during power-down");
    AST_PD_LEADS_CLOCK: assert property (
        power_down_pin && $fell(sclk) |-> $past(power_down_pin, 250))
        else $error("clock pulse too soon after power-down rise");
    AST_PD_WIDTH: assert property (
        $fell(power_down_pin) |-> $past(power_down_pin, 300))
        else $error("power-down pulse too short");
    AST_SCLK_HALF: assert property (
        $fell(sclk) |-> !sclk [*8])
        else $error("serial clock low phase too short");
endmodule
`default_nettype wire

// *** sim/sensor_two_wire_register_port_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module sensor_two_wire_register_port_tb_top;
    typedef struct packed {
        logic                       wr;
        logic [stw_pkg::ADDR_W-1:0] addr;
        logic [stw_pkg::DATA_W-1:0] data;
    } stw_row_t;
    localparam int NROW = 9;
    // Writes carry the data sent, reads the data expected back
    localparam stw_row_t ROWS [NROW] = '{
        '{1'h1, 7'h00, 8'hA5}, '{1'h1, 7'h7F, 8'h3C}, '{1'h1, 7'h15, 8'h81},
        '{1'h0, 7'h7F, 8'h3C}, '{1'h0, 7'h00, 8'hA5}, '{1'h0, 7'h15, 8'h81},
        '{1'h0, 7'h42, 8'h00}, '{1'h1, 7'h15, 8'h5A}, '{1'h0, 7'h15, 8'h5A}};

    logic       clock_i, reset_i, cmd_valid, cmd_write, resync_pd, resync_wdog;
    logic [6:0] cmd_addr, wr_addr, wr_addr_b;
    logic [7:0] cmd_data, rsp_data, wr_data, wr_data_b;
    logic       cmd_ready, rsp_valid, wr_valid, wr_valid_b;
    logic       shutdown, shutdown_b, rd_done;
    int         n_errors = 0;
    int         cmp_count = 0;
    int         n_wr_b = 0;
    int         n_wr_a = 0;
    int         n_rd_a = 0;

    stw_link_if link_a ();
    stw_link_if link_b ();

    stw_device #(.WDOG_CYC(20'h00064)) i_stw_device (
        .clock_i(clock_i), .reset_i(reset_i), .link(link_a),
        .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .rd_done_o(rd_done), .shutdown_o(shutdown));
    stw_device #(.WDOG_CYC(20'h00064)) i_stw_device_b (
        .clock_i(clock_i), .reset_i(reset_i), .link(link_b),
        .wr_valid_o(wr_valid_b), .wr_addr_o(wr_addr_b),
        .wr_data_o(wr_data_b), .rd_done_o(), .shutdown_o(shutdown_b));
    stw_host #(.PD_CYC(20'h000C8), .WDOG_WAIT(20'h00074)) i_stw_host (
        .clock_i(clock_i), .reset_i(reset_i), .link(link_a),
        .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
        .resync_pd_i(resync_pd), .resync_wdog_i(resync_wdog),
        .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data));
    stw_link_props i_stw_link_props (
        .clock_i(clock_i), .reset_i(reset_i), .sclk(link_a.sclk),
        .power_down_pin(link_a.power_down_pin),
        .host_sdio_out(link_a.host_sdio_out),
        .host_sdio_oe(link_a.host_sdio_oe),
        .dev_sdio_out(link_a.dev_sdio_out),
        .dev_sdio_oe(link_a.dev_sdio_oe));

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        if (wr_valid_b === 1'b1) begin
            n_wr_b <= n_wr_b + 1;
        end
        if (wr_valid === 1'b1) begin
            n_wr_a <= n_wr_a + 1;
        end
        if (rd_done === 1'b1) begin
            n_rd_a <= n_rd_a + 1;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_for(input bit rsp);
        int k;
        k = 0;
        while ((rsp ? rsp_valid : cmd_ready) !== 1'b1 && k < 2000) begin
            @(negedge clock_i);
            k++;
        end
        check({7'h00, rsp ? rsp_valid : cmd_ready}, 8'h01);
    endtask

    task automatic issue(input stw_row_t r);
        wait_for(1'b0);
        cmd_valid = 1'b1;
        cmd_write = r.wr;
        cmd_addr = r.addr;
        cmd_data = r.data;
        @(negedge clock_i);
        cmd_valid = 1'b0;
        @(negedge clock_i);
        if (r.wr) begin
            wait_for(1'b0);
            check({1'h0, wr_addr}, {1'h0, r.addr});
            check(wr_data, r.data);
        end else begin
            wait_for(1'b1);
            check(rsp_data, r.data);
        end
    endtask

    // Bench acts as host on the second link, one 160 ns clock per bit
    task automatic bit_out(input logic b);
        @(negedge clock_i);
        link_b.sclk = 1'b0;
        link_b.host_sdio_out = b;
        repeat (20) @(negedge clock_i);
        link_b.sclk = 1'b1;
        repeat (19) @(negedge clock_i);
    endtask

    task automatic frame_out(input logic [15:0] f);
        for (int j = 15; j >= 0; j--) begin
            bit_out(f[j]);
        end
        repeat (20) @(negedge clock_i);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        results();
    end

    initial begin
        reset_i = 1'b1;
        {cmd_valid, cmd_write, resync_pd, resync_wdog} = 4'h0;
        cmd_addr = 7'h00;
        cmd_data = 8'h00;
        link_b.sclk = 1'b1;
        link_b.power_down_pin = 1'b0;
        link_b.host_sdio_out = 1'b1;
        link_b.host_sdio_oe = 1'b1;
        repeat (16) @(negedge clock_i);
        check({7'h00, shutdown}, 8'h01);
        check({6'h00, cmd_ready, link_a.dev_sdio_oe}, 8'h00);
        reset_i = 1'b0;
        for (int i = 0; i < NROW; i++) begin
            issue(ROWS[i]);
        end
        // Power-down resync keeps registers and returns to service
        resync_pd = 1'b1;
        @(negedge clock_i);
        resync_pd = 1'b0;
        repeat (100) @(negedge clock_i);
        check({6'h00, shutdown, link_a.dev_sdio_oe}, 8'h02);
        wait_for(1'b0);
        repeat (10) @(negedge clock_i);
        check({7'h00, shutdown}, 8'h00);
        issue('{1'h0, 7'h7F, 8'h3C});
        resync_wdog = 1'b1;
        @(negedge clock_i);
        resync_wdog = 1'b0;
        issue('{1'h0, 7'h00, 8'hA5});
        // Abort a write mid data byte on the second link
        for (int j = 15; j > 4; j--) begin
            bit_out(ROWS[7][j]);
        end
        link_b.power_down_pin = 1'b1;
        repeat (600) @(negedge clock_i);
        check({7'h00, shutdown_b}, 8'h01);
        check(8'(n_wr_b), 8'h00);
        link_b.power_down_pin = 1'b0;
        repeat (20) @(negedge clock_i);
        frame_out({1'h1, 7'h15, 8'hC3});
        check({shutdown_b, wr_addr_b}, 8'h15);
        check(wr_data_b, 8'hC3);
        // Stray bits then idle past the timeout realign the port
        for (int j = 0; j < 5; j++) begin
            bit_out(1'b1);
        end
        repeat (200) @(negedge clock_i);
        frame_out({1'h1, 7'h2A, 8'h96});
        check({1'h0, wr_addr_b}, 8'h2A);
        check(wr_data_b, 8'h96);
        check(8'(n_wr_b), 8'h02);
        check(8'(n_wr_a), 8'h04);
        check(8'(n_rd_a), 8'h07);
        results();
    end
endmodule
`default_nettype wire
